// ==== bridge_defines.vh ====
// Constants for the half-bridge PWM control block.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef BRIDGE_DEFINES_VH
`define BRIDGE_DEFINES_VH
// Rate select codes
`define RATE_STOP 2'h0
`define RATE_80HZ 2'h1
`define RATE_100HZ 2'h2
`define RATE_200HZ 2'h3
// Channel assignment codes (00 = no PWM)
`define ASSIGN_NONE 2'h0
// Clock rate and PWM step counts (256 steps per period)
`define SYS_CLK_HZ 250000000
`define PWM_STEPS 256
`define STEP_80HZ (`SYS_CLK_HZ / (80 * `PWM_STEPS))
`define STEP_100HZ (`SYS_CLK_HZ / (100 * `PWM_STEPS))
`define STEP_200HZ (`SYS_CLK_HZ / (200 * `PWM_STEPS))
// Non-overlap time in ns and cycles (least time, rounded up)
`define DEAD_NS 500
`define DEAD_CYC ((`DEAD_NS * 250 + 999) / 1000)
// Reset values
`define FLAG_RESET 1'b0
`endif

// ==== pwm_channel.v ====
// One PWM channel: rate prescaler, 8-bit period counter, latched duty.
// Assumes a clock enable from the parent and a synchronous clear.
`timescale 1ns/10ps
`include "bridge_defines.vh"
module pwm_channel #(
  parameter STEP_80 = `STEP_80HZ,
  parameter STEP_100 = `STEP_100HZ,
  parameter STEP_200 = `STEP_200HZ
) (
  input wire clk, // System clock
  input wire rst_b, // Async reset, active low
  input wire ce, // Clock enable
  input wire clr, // Synchronous clear
  input wire [1:0] rate, // Rate select
  input wire [7:0] duty, // Requested duty
  output reg pwm_on // PWM level
);
  reg [1:0] rate_q;
  reg [7:0] duty_q;
  reg [7:0] cnt_q;
  reg [15:0] pre_q;
  reg [15:0] step_lim;
  wire step_tick;
  wire run;

  // Prescaler limit for the rate latched at period start
  always @* begin
    case (rate_q)
      `RATE_80HZ: step_lim = STEP_80[15:0] - 16'h0001;
      `RATE_100HZ: step_lim = STEP_100[15:0] - 16'h0001;
      `RATE_200HZ: step_lim = STEP_200[15:0] - 16'h0001;
      default: step_lim = 16'h0000;
    endcase
  end
  assign run = (rate_q != `RATE_STOP);
  assign step_tick = run && (pre_q == step_lim);

  // ************************************
  // Period engine
  // ************************************
  // Rate and duty change only at a period boundary; rate 00 or clear stops the channel at once
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_q <= 2'h0;
      duty_q <= 8'h00;
      cnt_q <= 8'h00;
      pre_q <= 16'h0000;
      pwm_on <= 1'b0;
    end else if (ce) begin
      if (clr || rate == `RATE_STOP) begin
        rate_q <= `RATE_STOP;
        cnt_q <= 8'h00;
        pre_q <= 16'h0000;
        pwm_on <= 1'b0;
      end else if (!run) begin
        rate_q <= rate;
        duty_q <= duty;
        cnt_q <= 8'h00;
        pre_q <= 16'h0000;
        pwm_on <= (duty != 8'h00);
      end else if (step_tick) begin
        pre_q <= 16'h0000;
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == 8'hFF) begin
          rate_q <= rate;
          duty_q <= duty;
          pwm_on <= (duty != 8'h00);
        end else begin
          pwm_on <= ((cnt_q + 8'h01) < duty_q);
        end
      end else begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end
endmodule // pwm_channel

// ==== bridge_ctrl.v ====
// Twelve half-bridge gate controller with three PWM channels.
// Assumes the serial front end presents settings as plain ports, and
// EN and the supply monitors arrive asynchronously.
//
// Summary of operation
// - Logic supply power-on clears all settings and tri-states all outputs.
// - Load supply dips do not disturb stored settings.
// - Enable high gives normal mode; outputs configurable, charge pump on.
// - Enable low gives sleep; switches off, settings back to reset values.
// - Floating enable reads low, so sleep is the default.
// - Logic supply below off threshold: port ignored, logic cleared, off.
// - After supply returns, reinitialize and power reset flag reads 0.
// - Enable-low reset is reported by flag 0 once back in normal mode.
// - Mode 00 activation bit keeps its switch on until cleared.
// - Any bridge may use any of three channels with 8-bit duty.
// - Rate code 01 80Hz, 10 100Hz, 11 200Hz per channel.
// - Rate and duty changes take effect without glitches.
// - Freewheel active or passive per bridge, passive after reset.
// - Active freewheel only when both on-times exceed the dead times.
// - Active freewheel turns on the complementary switch in off phase.
// - Mode 00 with both activation bits clear holds tri-state.
// - Rate code 00 stops the channel with its PWM off.
// - Nonzero rate on a stopped channel starts a new period.
`timescale 1ns/10ps
`include "bridge_defines.vh"
module bridge_ctrl #(
  parameter NB = 12,
  parameter DEAD = `DEAD_CYC,
  parameter STEP_80 = `STEP_80HZ,
  parameter STEP_100 = `STEP_100HZ,
  parameter STEP_200 = `STEP_200HZ
) (
  input wire SYS_CLK, // System clock, 250 MHz
  input wire RST_B, // Async reset, active low
  input wire CE, // Clock enable
  input wire EN, // Enable pin (pulled low)
  input wire VDD_OK, // Logic supply above threshold
  input wire LOAD_SUPPLY_OK, // Load supply present
  input wire WR_EN, // Settings write strobe
  input wire [NB-1:0] UPPER_SWITCH_EN, // Upper activation bits
  input wire [NB-1:0] LOWER_SWITCH_EN, // Lower activation bits
  input wire [2*NB-1:0] BRIDGE_CHANNEL_ASSIGN, // Channel per bridge
  input wire [NB-1:0] FREEWHEEL_ACTIVE, // Active freewheel per bridge
  input wire [5:0] CHANNEL_RATE_SELECT, // Rate codes ch3..ch1
  input wire [23:0] CHANNEL_DUTY, // Duty ch3..ch1
  input wire FLAG_CLEAR, // Host sets flag to 1
  output wire [NB-1:0] UPPER_SWITCH, // Upper gate drive, one flop per bridge
  output wire [NB-1:0] LOWER_SWITCH, // Lower gate drive, one flop per bridge
  output reg CHARGE_PUMP_ON, // Charge pump enable
  output reg PORT_READY, // Serial port accepted
  output reg POWER_RESET_FLAG_N // Power reset flag, 0 after reset
);
  // ************************************
  // Input synchronisers
  // ************************************
  reg en_m, en_s, vdd_m, vdd_s, ld_m, ld_s;
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      en_m <= 1'b0;
      en_s <= 1'b0;
      vdd_m <= 1'b0;
      vdd_s <= 1'b0;
      ld_m <= 1'b0;
      ld_s <= 1'b0;
    end else if (CE) begin
      en_m <= EN;
      en_s <= en_m;
      vdd_m <= VDD_OK;
      vdd_s <= vdd_m;
      ld_m <= LOAD_SUPPLY_OK;
      ld_s <= ld_m;
    end
  end

  // Logic clear: supply loss or sleep both wipe settings
  wire logic_clr = !vdd_s || !en_s;
  wire normal = vdd_s && en_s;

  // ************************************
  // Settings registers
  // ************************************
  // Load supply state is not part of the clear, so dips keep settings
  reg [NB-1:0] up_en_q, lo_en_q, fw_q;
  reg [2*NB-1:0] asg_q;
  reg [5:0] rate_q;
  reg [23:0] duty_q;
  reg flag_q;
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      up_en_q <= {NB{1'b0}};
      lo_en_q <= {NB{1'b0}};
      fw_q <= {NB{1'b0}};
      asg_q <= {2*NB{1'b0}};
      rate_q <= 6'h00;
      duty_q <= 24'h000000;
      flag_q <= `FLAG_RESET;
    end else if (CE) begin
      if (logic_clr) begin
        up_en_q <= {NB{1'b0}};
        lo_en_q <= {NB{1'b0}};
        fw_q <= {NB{1'b0}};
        asg_q <= {2*NB{1'b0}};
        rate_q <= 6'h00;
        duty_q <= 24'h000000;
        flag_q <= `FLAG_RESET;
      end else if (WR_EN) begin
        up_en_q <= UPPER_SWITCH_EN;
        lo_en_q <= LOWER_SWITCH_EN;
        fw_q <= FREEWHEEL_ACTIVE;
        asg_q <= BRIDGE_CHANNEL_ASSIGN;
        rate_q <= CHANNEL_RATE_SELECT;
        duty_q <= CHANNEL_DUTY;
        if (FLAG_CLEAR) begin
          flag_q <= 1'b1;
        end
      end
    end
  end

  // ************************************
  // PWM channels
  // ************************************
  wire [2:0] ch_on;
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_ch
      pwm_channel #(
        .STEP_80(STEP_80),
        .STEP_100(STEP_100),
        .STEP_200(STEP_200)
      ) u_ch (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .ce(CE),
        .clr(logic_clr),
        .rate(rate_q[2*c+1:2*c]),
        .duty(duty_q[8*c+7:8*c]),
        .pwm_on(ch_on[c])
      );
    end
  endgenerate

  // ************************************
  // Per-bridge drive with non-overlap
  // ************************************
  // Active freewheel needs duty far enough from 0 and 255 to fit both dead times
  localparam [7:0] FW_MIN = 8'h02;
  localparam [7:0] FW_MAX = 8'hFD;
  genvar b;
  generate
    for (b = 0; b < NB; b = b + 1) begin : g_br
      wire [1:0] a = asg_q[2*b+1:2*b];
      wire use_pwm = (a != `ASSIGN_NONE);
      wire [1:0] ci = a - 2'h1;
      wire p = use_pwm ? ch_on[ci] : 1'b1;
      wire [7:0] d = duty_q[8*ci+:8];
      wire fw_ok = fw_q[b] && use_pwm && (d >= FW_MIN) && (d <= FW_MAX);
      reg want_up, want_lo;
      reg up_q, lo_q;
      reg [7:0] dead_q;
      // Each bridge owns its own output bits, so each bit has one driver
      assign UPPER_SWITCH[b] = up_q;
      assign LOWER_SWITCH[b] = lo_q;
      reg [1:0] last_q;
      // Requested switch state; tri-state when nothing is active
      always @* begin
        want_up = up_en_q[b] && p;
        want_lo = lo_en_q[b] && p;
        if (fw_ok && lo_en_q[b] && !up_en_q[b] && !p) begin
          want_up = 1'b1;
        end
        if (fw_ok && up_en_q[b] && !lo_en_q[b] && !p) begin
          want_lo = 1'b1;
        end
        if (want_up && want_lo) begin
          want_lo = 1'b0; // Both requested: keep lower off for safety
        end
        if (!normal) begin
          want_up = 1'b0;
          want_lo = 1'b0;
        end
      end
      // Any change of side waits the dead time with both off
      always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
          up_q <= 1'b0;
          lo_q <= 1'b0;
          dead_q <= 8'h00;
          last_q <= 2'h0;
        end else if (CE) begin
          if (want_up && last_q == 2'h2 || want_lo && last_q == 2'h1) begin
            up_q <= 1'b0;
            lo_q <= 1'b0;
            dead_q <= DEAD[7:0];
            last_q <= 2'h0;
          end else if (dead_q != 8'h00) begin
            dead_q <= dead_q - 8'h01;
          end else begin
            up_q <= want_up && ld_s;
            lo_q <= want_lo && ld_s;
            last_q <= want_up ? 2'h1 : (want_lo ? 2'h2 : last_q);
          end
        end
      end
    end
  endgenerate

  // ************************************
  // Status outputs
  // ************************************
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      CHARGE_PUMP_ON <= 1'b0;
      PORT_READY <= 1'b0;
      POWER_RESET_FLAG_N <= 1'b0;
    end else if (CE) begin
      CHARGE_PUMP_ON <= normal;
      PORT_READY <= vdd_s;
      POWER_RESET_FLAG_N <= flag_q;
    end
  end
endmodule // bridge_ctrl

// ==== en_host.sv ====
// Host side of the enable pin: drives it or leaves it floating.
// Assumes the block's pull-down is the only other load on the line.
`timescale 1ns/10ps
module en_host (
  input wire drive, // Host drives the pin
  input wire level, // Driven level
  output wire pin // Level seen by the block
);
  // A released pin must settle low, never hold its last value
  tri0 line;
  assign line = drive ? level : 1'bz;
  assign pin = line;
endmodule // en_host

// ==== bridge_ctrl_properties.sv ====
// Checker of gate drives, pump and flag against mode and supply pins.
// Assumes a bind onto bridge_ctrl; CE is held high by the bench.
`timescale 1ns/10ps
module bridge_chk #(
  parameter NB = 12,
  parameter DEAD = 125
) (
  input wire SYS_CLK, // Clock
  input wire RST_B, // Reset, active low
  input wire EN, // Enable pin
  input wire VDD_OK, // Logic supply good
  input wire WR_EN, // Write strobe
  input wire [NB-1:0] UPPER_SWITCH_EN, // Upper bits
  input wire [NB-1:0] LOWER_SWITCH_EN, // Lower bits
  input wire [2*NB-1:0] BRIDGE_CHANNEL_ASSIGN, // Channel per bridge
  input wire [NB-1:0] UPPER_SWITCH, // Upper drive
  input wire [NB-1:0] LOWER_SWITCH, // Lower drive
  input wire CHARGE_PUMP_ON, // Pump
  input wire PORT_READY, // Port alive
  input wire POWER_RESET_FLAG_N // Reset flag
);
  // ****************
  // Output rules
  // ****************
  // Synchroniser latency is 2 cycles, so waits allow 3 plus margin
  localparam int DW = DEAD + 4;
  wire wr = WR_EN && EN && VDD_OK;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  property p_no_overlap;
    (UPPER_SWITCH & LOWER_SWITCH) == '0; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both switches on");
  property p_sleep;
    !EN [*4] |-> !CHARGE_PUMP_ON && UPPER_SWITCH == '0 && LOWER_SWITCH == '0; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  property p_vdd_off;
    !VDD_OK [*4] |-> !PORT_READY && UPPER_SWITCH == '0; endproperty
  a_vdd_off: assert property (p_vdd_off) else $error("supply loss ignored");
  property p_pump;
    (EN && VDD_OK) [*4] |-> CHARGE_PUMP_ON; endproperty
  a_pump: assert property (p_pump) else $error("pump off in normal mode");
  property p_flag_vdd;
    !VDD_OK ##1 VDD_OK [*3] |-> !POWER_RESET_FLAG_N; endproperty
  a_flag_vdd: assert property (p_flag_vdd) else $error("flag not cleared");
  property p_flag_en;
    !EN ##1 (EN && VDD_OK) [*3] |-> !POWER_RESET_FLAG_N; endproperty
  a_flag_en: assert property (p_flag_en) else $error("enable reset unseen");
  property p_tristate;
    wr && UPPER_SWITCH_EN == '0 && LOWER_SWITCH_EN == '0 && BRIDGE_CHANNEL_ASSIGN == '0
      |-> ##2 UPPER_SWITCH == '0 && LOWER_SWITCH == '0; endproperty
  a_tristate: assert property (p_tristate) else $error("not tri-state");
  property p_cont;
    wr && UPPER_SWITCH_EN[0] && !LOWER_SWITCH_EN[0] && BRIDGE_CHANNEL_ASSIGN[1:0] == 2'h0
      |-> ##[2:DW] UPPER_SWITCH[0]; endproperty
  a_cont: assert property (p_cont) else $error("upper switch not on");
endmodule // bridge_chk
bind bridge_ctrl bridge_chk #(.NB(NB), .DEAD(DEAD)) chk_i (.*);

// ==== tb_top.sv ====
// Self-checking bench for bridge_ctrl with short PWM steps.
// Assumes the checker file is compiled alongside; CE is held high.
`timescale 1ns/10ps
module tb_top;
  reg clk = 0, rst_b = 0, en_drv = 0, en_val = 0, vdd = 0, load = 1, wr = 0, fc = 0;
  reg [11:0] ue = 12'h000, le = 12'h000, fw = 12'h000;
  reg [23:0] asg = 24'h000000, duty = 24'h000000;
  reg [5:0] rate = 6'h00;
  wire en, cp, pr, fl;
  wire [11:0] us, ls;
  integer err_total = 0, n_tests = 0, cyc = 0, k, h, r;
  // ****************
  // Clock, pin model, device
  // ****************
  always #2 clk = ~clk;
  en_host host (.drive(en_drv), .level(en_val), .pin(en));
  bridge_ctrl #(.DEAD(4), .STEP_80(2), .STEP_100(3), .STEP_200(4)) uut (
    .SYS_CLK(clk), .RST_B(rst_b), .CE(1'b1), .EN(en), .VDD_OK(vdd),
    .LOAD_SUPPLY_OK(load), .WR_EN(wr), .UPPER_SWITCH_EN(ue), .LOWER_SWITCH_EN(le),
    .BRIDGE_CHANNEL_ASSIGN(asg), .FREEWHEEL_ACTIVE(fw), .CHANNEL_RATE_SELECT(rate),
    .CHANNEL_DUTY(duty), .FLAG_CLEAR(fc), .UPPER_SWITCH(us), .LOWER_SWITCH(ls),
    .CHARGE_PUMP_ON(cp), .PORT_READY(pr), .POWER_RESET_FLAG_N(fl));
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // One-cycle write of all settings, launched off the sampling edge
  task wr_set;
    begin
      @(negedge clk) wr = 1;
      @(negedge clk) wr = 0;
    end
  endtask
  // On-time and rising edges of one upper drive over n cycles
  task meas(input integer b, input integer n);
    reg p;
    begin
      h = 0;
      r = 0;
      p = us[b];
      repeat (n) begin
        @(negedge clk);
        if (us[b] === 1'b1 && p === 1'b0) r = r + 1;
        h = h + us[b];
        p = us[b];
      end
    end
  endtask
  // Hang guard; the whole run needs under 9000 cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end
  // ****************
  // Test sequence
  // ****************
  initial begin
    wt(2);
    rst_b = 1;
    chk(us | ls, 12'h000);
    en_drv = 1; en_val = 1; vdd = 1; wt(4);
    chk(cp, 1'b1);
    chk(fl, 1'b0);
    fc = 1; wr_set; fc = 0; wt(2);
    chk(fl, 1'b1);
    ue = 12'h001; wr_set; wt(2);
    chk(us[0], 1'b1);
    ue = 12'h000; le = 12'h001; wr_set; wt(8);
    chk({us[0], ls[0]}, 2'h1);
    load = 0; wt(4);
    chk(ls[0], 1'b0);
    load = 1; wt(8);
    chk(ls[0], 1'b1);
    $display("continuous drive done");
    le = 12'h000; ue = 12'h00E; asg = 24'h0000E4; duty = 24'hFF8140; wr_set; wt(600);
    chk(us, 12'h000);
    rate = 6'h39; wr_set; wt(1100);
    for (k = 1; k <= 3; k = k + 1) begin
      meas(k, 256 * (k + 1));
      chk(h, duty[8*k-8 +: 8] * (k + 1));
      chk(r, 1);
    end
    // Duty change mid-period must still give one clean pulse per period
    duty[7:0] = 8'h10; wr_set; meas(1, 512);
    chk(r, 1);
    meas(1, 512);
    chk(h, 32'h20);
    $display("pwm rates done");
    ue = 12'h000; le = 12'h002; duty[7:0] = 8'h80; wr_set; wt(1100);
    meas(1, 512);
    chk(h, 0);
    fw = 12'h002; wr_set; wt(600); meas(1, 512);
    chk(h > 0 && h < 256, 1'b1);
    // Duty too short to fit both dead times: freewheel must stay passive
    duty[7:0] = 8'h01; wr_set; wt(600); meas(1, 512);
    chk(h, 0);
    $display("freewheel done");
    en_drv = 0; wt(4);
    chk({cp, fl, us | ls}, 14'h0000);
    en_drv = 1; wt(4);
    chk({fl, us | ls}, 13'h0000);
    $display("sleep done");
    vdd = 0; wt(4);
    chk(pr, 1'b0);
    vdd = 1; wt(4);
    chk(fl, 1'b0);
    $display("supply reset done");
    end_sim;
  end
endmodule // tb_top
